// *** design/sram_host.sv ***
// Controller driving an asynchronous 256K x 1 static memory through its pins
`include "sram_host_cfg.svh"

////////////////////////////////////////////////////////////////////////////////
// Summary of operation
// - A write lasts only while select and strobe are both low.
// - Input data setup and hold referenced to the edge ending the write.
// - Strobe stays high throughout every read.
// - Held-low select lets back-to-back reads follow address changes.
// - Address is valid no later than select falling.
module sram_host (
    input wire logic clk,
    input wire logic rst_n,
    input wire logic req_valid,
    input wire logic req_write,
    input wire logic [`ADDR_W-1:0] req_addr,
    input wire logic req_data,
    output logic req_ready,
    output logic rsp_valid,
    output logic rsp_data,
    output sram_host_pkg::mem_pins_t mem,
    input wire logic mem_dout
);
    sram_host_pkg::state_t state_q, state_d;
    logic [`CNT_W-1:0] cnt_q, cnt_d;
    logic rsp_valid_d, rsp_data_d, req_ready_d;
    sram_host_pkg::mem_pins_t mem_d;

    wire take = req_valid & req_ready;
    wire cnt_done = (cnt_q == `CNT_ONE);
    // Reads chain with select held low; a write after a read also starts with select still low
    wire chain_rd = take & ~req_write;

    ////////////////////////////////////////////////////////////////////////////
    always_comb begin
        state_d = state_q;
        cnt_d = cnt_q;
        mem_d = mem;
        rsp_valid_d = 1'b0;
        rsp_data_d = rsp_data;
        req_ready_d = 1'b0;
        unique case (state_q)
            sram_host_pkg::ST_IDLE: begin
                req_ready_d = 1'b1;
                if (take && req_write) begin
                    // Address, data, select and strobe all change on the same edge
                    mem_d.addr = req_addr;
                    mem_d.din = req_data;
                    mem_d.cs_n = 1'b0;
                    mem_d.we_n = 1'b0;
                    cnt_d = `CNT_W'(`WR_CYC);
                    state_d = sram_host_pkg::ST_WRITE;
                    req_ready_d = 1'b0;
                end else if (chain_rd) begin
                    mem_d.addr = req_addr;
                    mem_d.cs_n = 1'b0;
                    mem_d.we_n = 1'b1;
                    cnt_d = `CNT_W'(`RD_CYC);
                    state_d = sram_host_pkg::ST_READ;
                    req_ready_d = 1'b0;
                end else begin
                    mem_d.cs_n = 1'b1;
                    mem_d.we_n = 1'b1;
                end
            end
            sram_host_pkg::ST_READ: begin
                cnt_d = cnt_q - `CNT_ONE;
                if (cnt_done) begin
                    rsp_valid_d = 1'b1;
                    rsp_data_d = mem_dout;
                    state_d = sram_host_pkg::ST_IDLE;
                    req_ready_d = 1'b1;
                    // Select stays low into the next read if one follows
                    cnt_d = `CNT_ZERO;
                end
            end
            sram_host_pkg::ST_WRITE: begin
                cnt_d = cnt_q - `CNT_ONE;
                if (cnt_done) begin
                    // Strobe rises first; data and address held past it
                    mem_d.we_n = 1'b1;
                    state_d = sram_host_pkg::ST_RECOVER;
                end
            end
            sram_host_pkg::ST_RECOVER: begin
                mem_d.cs_n = 1'b1;
                req_ready_d = 1'b1;
                state_d = sram_host_pkg::ST_IDLE;
            end
        endcase
    end

    ////////////////////////////////////////////////////////////////////////////
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            state_q <= sram_host_pkg::ST_IDLE;
            cnt_q <= `CNT_ZERO;
            mem <= '{cs_n: 1'b1, we_n: 1'b1, addr: '0, din: 1'b0};
            rsp_valid <= 1'b0;
            rsp_data <= 1'b0;
            req_ready <= 1'b0;
        end else begin
            state_q <= state_d;
            cnt_q <= cnt_d;
            mem <= mem_d;
            rsp_valid <= rsp_valid_d;
            rsp_data <= rsp_data_d;
            req_ready <= req_ready_d;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    a_read_strobe_high: assert property (@(posedge clk) disable iff (!rst_n)
        state_q == sram_host_pkg::ST_READ |-> mem.we_n)
        else $error("strobe low during read");
    a_write_selected: assert property (@(posedge clk) disable iff (!rst_n)
        !mem.we_n |-> !mem.cs_n)
        else $error("strobe low without select");
    a_write_width: assert property (@(posedge clk) disable iff (!rst_n)
        $fell(mem.we_n) |-> !mem.we_n [*2] ##1 mem.we_n)
        else $error("write pulse width wrong");
    a_write_hold: assert property (@(posedge clk) disable iff (!rst_n)
        $rose(mem.we_n) |-> $stable(mem.din) && $stable(mem.addr) && !mem.cs_n)
        else $error("data or address moved at write end");
    a_read_addr_stable: assert property (@(posedge clk) disable iff (!rst_n)
        state_q == sram_host_pkg::ST_READ && $past(state_q) == sram_host_pkg::ST_READ
        |-> $stable(mem.addr))
        else $error("address changed during read");
    a_read_latency: assert property (@(posedge clk) disable iff (!rst_n)
        state_q == sram_host_pkg::ST_IDLE && chain_rd |-> ##4 (rsp_valid && req_ready))
        else $error("read response late");
    a_idle_deselect: assert property (@(posedge clk) disable iff (!rst_n)
        $past(state_q) == sram_host_pkg::ST_RECOVER |-> mem.cs_n)
        else $error("select held after write");
    a_ready_single: assert property (@(posedge clk) disable iff (!rst_n)
        rsp_valid |-> req_ready)
        else $error("not ready after read");

    ////////////////////////////////////////////////////////////////////////////
    // Reset and hand-off checks
    // The reset-value check runs without disable so the reset values themselves are covered
    a_reset_pins_idle: assert property (@(posedge clk)
        !rst_n |=> mem.cs_n && mem.we_n && !req_ready && !rsp_valid)
        else $error("pins not idle after reset");
    a_first_ready: assert property (@(posedge clk) disable iff (!rst_n)
        $rose(rst_n) |=> req_ready)
        else $error("not ready after reset release");
    a_ready_only_idle: assert property (@(posedge clk) disable iff (!rst_n)
        req_ready |-> state_q == sram_host_pkg::ST_IDLE)
        else $error("ready outside idle");
    a_take_in_idle: assert property (@(posedge clk) disable iff (!rst_n)
        take |-> state_q == sram_host_pkg::ST_IDLE)
        else $error("request taken while busy");

    // Pin values launched by a taken request, address held while busy, deselected when none is taken
    a_take_read_pins: assert property (@(posedge clk) disable iff (!rst_n)
        take && !req_write |=> !mem.cs_n && mem.we_n && mem.addr == $past(req_addr))
        else $error("read pins wrong after take");
    a_take_write_pins: assert property (@(posedge clk) disable iff (!rst_n)
        take && req_write |=> !mem.cs_n && !mem.we_n && mem.addr == $past(req_addr)
        && mem.din == $past(req_data))
        else $error("write pins wrong after take");
    a_busy_addr_held: assert property (@(posedge clk) disable iff (!rst_n)
        req_valid && !req_ready |=> $stable(mem.addr))
        else $error("address moved while busy");
    a_idle_deselect_next: assert property (@(posedge clk) disable iff (!rst_n)
        state_q == sram_host_pkg::ST_IDLE && !take |=> mem.cs_n && mem.we_n)
        else $error("select held in idle");

    // Write pulse shape; the strobe ends the write, select lifts after
    a_write_pins_stable: assert property (@(posedge clk) disable iff (!rst_n)
        !mem.we_n && $past(!mem.we_n) |-> $stable(mem.din) && $stable(mem.addr))
        else $error("data moved inside write");
    a_recover_strobe_high: assert property (@(posedge clk) disable iff (!rst_n)
        state_q == sram_host_pkg::ST_RECOVER |-> mem.we_n && !mem.cs_n)
        else $error("recover pins wrong");
    a_write_end_hold: assert property (@(posedge clk) disable iff (!rst_n)
        $rose(mem.we_n) |=> $stable(mem.addr) && $stable(mem.din))
        else $error("hold after write end broken");
    a_deselect_after_write: assert property (@(posedge clk) disable iff (!rst_n)
        $rose(mem.we_n) |=> mem.cs_n)
        else $error("select not lifted after write");
    a_write_cycle_length: assert property (@(posedge clk) disable iff (!rst_n)
        take && req_write |-> ##4 req_ready)
        else $error("write cycle length wrong");

    // Read side: select low, one-cycle response, data held between reads
    a_read_selected: assert property (@(posedge clk) disable iff (!rst_n)
        state_q == sram_host_pkg::ST_READ |-> !mem.cs_n)
        else $error("select high during read");
    a_rsp_one_cycle: assert property (@(posedge clk) disable iff (!rst_n)
        rsp_valid |=> !rsp_valid)
        else $error("response longer than one cycle");
    a_rsp_in_idle: assert property (@(posedge clk) disable iff (!rst_n)
        rsp_valid |-> state_q == sram_host_pkg::ST_IDLE)
        else $error("response outside idle");
    a_rsp_data_hold: assert property (@(posedge clk) disable iff (!rst_n)
        $changed(rsp_data) |-> rsp_valid)
        else $error("read data moved without response");
    a_cnt_bounded: assert property (@(posedge clk) disable iff (!rst_n)
        cnt_q <= `CNT_W'(`RD_CYC))
        else $error("wait counter out of range");

    c_read: cover property (@(posedge clk) disable iff (!rst_n) rsp_valid);
    c_write: cover property (@(posedge clk) disable iff (!rst_n) $rose(mem.we_n));
    c_chained: cover property (@(posedge clk) disable iff (!rst_n)
        rsp_valid ##1 (state_q == sram_host_pkg::ST_READ && !mem.cs_n));
    c_write_after_read: cover property (@(posedge clk) disable iff (!rst_n)
        rsp_valid ##1 (state_q == sram_host_pkg::ST_WRITE));
endmodule // sram_host

// *** design/sram_host_cfg.svh ***
// Timing constants and widths for the one-bit static memory controller
`ifndef SRAM_HOST_CFG_SVH
`define SRAM_HOST_CFG_SVH
`define ADDR_W 18
`define CLK_PERIOD_NS 25
// Read access time, address valid to data valid, ns
`define T_ACCESS_NS 45
// Write pulse width, ns
`define T_WPULSE_NS 40
// Data setup to write end, ns
`define T_DSETUP_NS 25
// Access rounds up to whole cycles, plus one for sampling margin
`define RD_CYC ((`T_ACCESS_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS + 1)
`define WR_CYC ((`T_WPULSE_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)
`define CNT_W 4
`define CNT_ZERO 4'h0
`define CNT_ONE 4'h1
`endif

// *** design/sram_host_pkg.sv ***
// Types for the one-bit static memory controller
package sram_host_pkg;
    typedef enum logic [1:0] {
        ST_IDLE,
        ST_READ,
        ST_WRITE,
        ST_RECOVER
    } state_t;
    typedef struct packed {
        logic cs_n;
        logic we_n;
        logic [17:0] addr;
        logic din;
    } mem_pins_t;
endpackage

// *** test/sram_bit_model.sv ***
// Behavioural one-bit static memory facing the controller pins
module sram_bit_model (
    input wire sram_host_pkg::mem_pins_t pins,
    output logic dout
);
    timeunit 1ns;
    timeprecision 1ps;
    logic cells [bit [17:0]];
    logic last = 1'b0;
    always @(pins) begin
        if (!pins.cs_n && !pins.we_n) cells[pins.addr] = pins.din;
    end
    // Floating pin shows the inverse of its last value so a late sample cannot pass
    always @(pins, last) begin
        if (!pins.cs_n && pins.we_n) begin
            dout = cells.exists(pins.addr) ? cells[pins.addr] : 1'b0;
            last = dout;
        end else begin
            dout = ~last;
        end
    end
endmodule // sram_bit_model

// *** test/sram_host_tb.sv ***
// Self-checking bench for the static memory controller
module sram_host_tb;
    timeunit 1ns;
    timeprecision 1ps;
    logic clk = 1'b0;
    logic rst_n = 1'b0;
    logic req_valid = 1'b0;
    logic req_write = 1'b0;
    logic [17:0] req_addr = 18'h0;
    logic req_data = 1'b0;
    logic req_ready, rsp_valid, rsp_data, mem_dout;
    sram_host_pkg::mem_pins_t mem;
    logic shadow [bit [17:0]];
    int err_count = 0;
    int samples_checked = 0;
    sram_host dut (.clk(clk), .rst_n(rst_n), .req_valid(req_valid), .req_write(req_write),
        .req_addr(req_addr), .req_data(req_data), .req_ready(req_ready),
        .rsp_valid(rsp_valid), .rsp_data(rsp_data), .mem(mem), .mem_dout(mem_dout));
    sram_bit_model model (.pins(mem), .dout(mem_dout));
    initial begin
        forever #12.5 clk = ~clk;
    end
    function automatic logic expect_bit(input logic [17:0] a);
        return shadow.exists(a) ? shadow[a] : 1'b0;
    endfunction
    task automatic check_bit(input string what, input logic exp, input logic got);
        samples_checked++;
        if (got !== exp) begin
            err_count++;
            $display("mismatch %s expected %b seen %b", what, exp, got);
        end
    endtask
    task automatic finish_test();
        $display("checked %0d errors %0d", samples_checked, err_count);
        if (err_count == 0 && samples_checked > 0) $display("Regression OK");
        else $display("Regression broken");
        $finish;
    endtask
    task automatic step();
        @(posedge clk);
        #2;
    endtask
    // Called just after an edge; next call may follow at once for back-to-back reads
    task automatic xfer(input logic wr, input logic [17:0] a, input logic d);
        int n = 0;
        req_valid = 1'b1;
        req_write = wr;
        req_addr = a;
        req_data = d;
        while (req_ready !== 1'b1 && n < 20) begin
            step();
            n++;
        end
        check_bit("req_ready", 1'b1, req_ready);
        step();
        req_valid = 1'b0;
        step();
        check_bit("mem.cs_n", 1'b0, mem.cs_n);
        check_bit("mem.we_n", !wr, mem.we_n);
        if (wr) begin
            shadow[a] = d;
            check_bit("mem.din", d, mem.din);
            return;
        end
        step();
        check_bit("rsp_valid early", 1'b0, rsp_valid);
        step();
        check_bit("rsp_valid", 1'b1, rsp_valid);
        check_bit("rsp_data", expect_bit(a), rsp_data);
    endtask
    initial begin
        void'($urandom(99));
        repeat (12) @(posedge clk);
        #2;
        rst_n = 1'b1;
        step();
        xfer(1'b1, 18'h0, 1'b1);
        xfer(1'b1, 18'h3ffff, 1'b0);
        xfer(1'b0, 18'h0, 1'b0);
        xfer(1'b0, 18'h3ffff, 1'b0);
        xfer(1'b0, 18'h0, 1'b0);
        for (int i = 0; i < 200; i++)
            xfer(1'($urandom), 18'($urandom) & 18'h3000f, 1'($urandom));
        finish_test();
    end
    initial begin
        #100000;
        err_count++;
        finish_test();
    end
endmodule // sram_host_tb
